/* hdl/asrc_pkg.sv */
// Package for the host-side asynchronous static RAM controller.
// Assumes a single 10 MHz clock; all pin timing derives from it.
package asrc_pkg;
    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 13;          // 8192 words
    localparam int DATA_W = 8;           // Byte wide
    // ------------------------------------------------------------
    // Timing (slowest grade, ns) and derived cycle counts
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;  // 10 MHz
    localparam int T_CYCLE_NS = 35;      // Least read/write cycle time
    localparam int T_ACCESS_NS = 35;     // Longest address access time
    localparam int T_STROBE_NS = 20;     // Least store-strobe width
    localparam int T_OFF_NS = 12;        // Longest output turn-off
    // Least times round up, at least one cycle
    localparam int CYC_CYCLE = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_ACCESS = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_STROBE = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_OFF = (T_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ACCESS = CNT_W'(CYC_ACCESS);
    localparam logic [CNT_W-1:0] CNT_STROBE = CNT_W'(CYC_STROBE);
    localparam logic [CNT_W-1:0] CNT_OFF = CNT_W'(CYC_OFF);
    localparam logic [CNT_W-1:0] CNT_SYNC = 4'h1;  // Extra read cycle for the synchroniser
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,  // Deselected
        ST_RSET = 3'b001,  // Address stable, select on, gate on
        ST_RACC = 3'b010,  // Waiting access time
        ST_WSET = 3'b011,  // Address/data stable, select on
        ST_WSTB = 3'b100,  // Store strobe low
        ST_REC  = 3'b101   // Turn-off/recovery gap, deselected only after a read; select held after a write
    } asrc_state_t;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;   // Word address
        logic select_low_active;   // Low-active select pin level
        logic select_high_active;  // High-active select pin level
        logic gate_b;              // Output gate, active low
        logic store_b;             // Store strobe, active low
        logic [DATA_W-1:0] dout;   // Data driven to the RAM
        logic dq_oe;               // Host drives the data lines
    } asrc_pins_t;
    typedef struct packed {
        asrc_state_t st;
        logic [CNT_W-1:0] cnt;
        asrc_pins_t pins;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
        logic q1_busy;
    } asrc_regs_t;
    localparam asrc_pins_t PINS_IDLE = '{addr: '0, select_low_active: 1'b1,
        select_high_active: 1'b0, gate_b: 1'b1, store_b: 1'b1,
        dout: '0, dq_oe: 1'b0};
endpackage

/* hdl/asrc_ctrl.sv */
// Host controller driving an 8K x 8 asynchronous static RAM by its pins.
// Assumes the RAM data pins are resolved in the testbench from bidir_data_lines_oe_o.
//
// Behaviour
// R01 - RAM holds 8192 bytes, 13-bit address
// R02 - Store when selected and strobe low
// R03 - Host keeps store strobe high reading
// R04 - Combined select: low-active low, high-active high
// R05 - Gate after strobe fall keeps outputs off
// R06 - Gate high keeps outputs off in write
// R07 - Read data valid within access time
// R08 - Address valid before select becomes active; the controller sets address and select on the same edge
// R09 - Continuous read follows address, holds 4 ns
// R10 - Outputs off faster than on, no fights
// R11 - Strobe turn-off faster than re-enable
// R12 - Host gives minimums, waits for maximums
// R13 - Cycle time at least the grade minimum
// R14 - Short strobe allowed only with gate high
// R15 - Deselected RAM neither drives nor stores
`timescale 1ns/10ps
module asrc_ctrl (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,                            // Clock enable
    input wire logic req_i,                           // Request pulse/level
    input wire logic we_i,                            // 1 = write
    input wire logic [asrc_pkg::ADDR_W-1:0] addr_i,   // Word address
    input wire logic [asrc_pkg::DATA_W-1:0] wdata_i,  // Write byte
    output logic ready_o,                             // Can take a request
    output logic [asrc_pkg::DATA_W-1:0] rdata_o,      // Read byte
    output logic rvalid_o,                            // Read done pulse
    output logic [asrc_pkg::ADDR_W-1:0] word_select_lines_o,
    output logic select_low_active_o,
    output logic select_high_active_o,
    output logic gate_b_o,
    output logic store_b_o,
    output logic [asrc_pkg::DATA_W-1:0] bidir_data_lines_o,
    output logic bidir_data_lines_oe_o,
    input wire logic [asrc_pkg::DATA_W-1:0] bidir_data_lines_i
);
    import asrc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    asrc_regs_t r;       // Registered state
    asrc_regs_t next_r;  // Next state
    logic [DATA_W-1:0] dq_s1;  // First synchroniser stage
    logic [DATA_W-1:0] dq_s2;  // Second stage, only one read by logic

    // Combined select seen by the RAM
    function automatic logic sel_on(input asrc_pins_t p);
        sel_on = !p.select_low_active && p.select_high_active;  // R04
    endfunction

    // Load counter, never below one cycle
    function automatic logic [CNT_W-1:0] hold_of(input logic [CNT_W-1:0] c);
        hold_of = (c == CNT_ZERO) ? 4'h1 : c;
    endfunction

    // ------------------------------------------------------------
    // Read data synchroniser
    // ------------------------------------------------------------
    // Data pins come from an asynchronous part, so two stages
    // Only the second stage feeds logic; the first may go
    // metastable when the RAM output moves near the edge
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dq_s1 <= '0;
            dq_s2 <= '0;
        end else if (ce_i) begin
            dq_s1 <= bidir_data_lines_i;
            dq_s2 <= dq_s1;
        end
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.rvalid = 1'b0;
        next_r.q1_busy = (r.st != ST_IDLE);
        if (r.cnt != CNT_ZERO) begin
            next_r.cnt = r.cnt - 4'h1;
        end
        unique case (r.st)
            ST_IDLE: begin
                // Idle: RAM deselected, so it neither drives nor stores
                next_r.pins = PINS_IDLE;  // R15
                next_r.pins.addr = r.pins.addr;
                if (req_i) begin
                    // Address placed with select, never after it
                    next_r.pins.addr = addr_i;  // R08
                    next_r.pins.select_low_active = 1'b0;
                    next_r.pins.select_high_active = 1'b1;
                    if (we_i) begin
                        // Gate stays high: outputs off through the write
                        next_r.pins.gate_b = 1'b1;  // R06
                        next_r.pins.dout = wdata_i;
                        next_r.st = ST_WSET;
                        next_r.cnt = CNT_ZERO;
                    end else begin
                        // Strobe held high for the whole read
                        next_r.pins.store_b = 1'b1;  // R03
                        next_r.pins.gate_b = 1'b0;
                        next_r.st = ST_RACC;
                        // Extra cycle so the byte reaches the second sync
                        // stage while selects still hold; one cycle per read
                        next_r.cnt = hold_of(CNT_ACCESS) + CNT_SYNC;  // R07
                    end
                end
            end
            ST_RSET: begin
                next_r.st = ST_RACC;
            end
            ST_RACC: begin
                // Wait out the longest access time before sampling
                // plus one extra cycle for the synchroniser
                // The byte itself is taken from the second stage below,
                // never from the raw pins
                if (r.cnt == CNT_ZERO && r.q1_busy) begin  // R12
                    next_r.st = ST_REC;
                    next_r.pins.gate_b = 1'b1;
                    next_r.pins.select_low_active = 1'b1;
                    next_r.pins.select_high_active = 1'b0;
                    next_r.cnt = hold_of(CNT_OFF);  // R10
                end
            end
            ST_WSET: begin
                // Data driven only while the RAM output gate is high
                next_r.pins.dq_oe = 1'b1;  // R05
                next_r.pins.store_b = 1'b0;  // R02
                next_r.st = ST_WSTB;
                next_r.cnt = hold_of(CNT_STROBE);  // R14
            end
            ST_WSTB: begin
                if (r.cnt == 4'h1) begin
                    // Strobe rises first; data held past it
                    next_r.pins.store_b = 1'b1;
                    next_r.st = ST_REC;
                    next_r.cnt = hold_of(CNT_OFF);  // R11
                end
            end
            ST_REC: begin
                // Gap keeps cycle time and lets outputs fall off
                next_r.pins.select_low_active = 1'b1;
                next_r.pins.select_high_active = 1'b0;
                next_r.pins.dq_oe = 1'b0;
                if (r.cnt <= 4'h1) begin  // R13
                    next_r.st = ST_IDLE;
                end
            end
            default: begin
                next_r.st = ST_IDLE;
                next_r.pins = PINS_IDLE;
            end
        endcase
        if (r.st == ST_RACC && r.cnt == CNT_ZERO && r.q1_busy) begin
            next_r.rdata = dq_s2;
            next_r.rvalid = 1'b1;  // R09
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r <= '{st: ST_IDLE, cnt: '0, pins: PINS_IDLE, rdata: '0,
                   rvalid: 1'b0, q1_busy: 1'b0};
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign ready_o = (r.st == ST_IDLE);
    assign rdata_o = r.rdata;
    assign rvalid_o = r.rvalid && ce_i;
    assign word_select_lines_o = r.pins.addr;  // R01
    assign select_low_active_o = r.pins.select_low_active;
    assign select_high_active_o = r.pins.select_high_active;
    assign gate_b_o = r.pins.gate_b;
    assign store_b_o = r.pins.store_b;
    assign bidir_data_lines_o = r.pins.dout;
    assign bidir_data_lines_oe_o = r.pins.dq_oe;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // All pins are registered, so a sample at the clock edge is what
    // the RAM saw for the whole of the preceding cycle
    // Strobe and gate never low together, or the RAM would drive
    a_strobe_gate_high: assert property (@(posedge clk_i) disable iff (!rst_b_i)  // R05
        !store_b_o |-> gate_b_o) else $error("strobe low with gate low");
    a_read_no_strobe: assert property (@(posedge clk_i) disable iff (!rst_b_i)  // R03
        !gate_b_o |-> store_b_o) else $error("strobe low during read");
    // Host drive only while the RAM output is gated off
    a_drive_gate_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)  // R06
        bidir_data_lines_oe_o |-> gate_b_o) else $error("bus fight");
    a_strobe_needs_sel: assert property (@(posedge clk_i) disable iff (!rst_b_i)  // R02
        !store_b_o |-> (!select_low_active_o && select_high_active_o))
        else $error("strobe while deselected");
    // Address frozen for as long as the select stays on
    a_addr_stable_sel: assert property (@(posedge clk_i) disable iff (!rst_b_i)  // R08
        (ce_i && !select_low_active_o && $past(!select_low_active_o))
        |-> $stable(word_select_lines_o)) else $error("address moved");
    a_idle_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i)  // R15
        select_low_active_o |-> !bidir_data_lines_oe_o && store_b_o)
        else $error("deselected activity");
    // Bound is loose on purpose: the clock enable may stall a read
    a_rd_completes: assert property (@(posedge clk_i) disable iff (!rst_b_i)  // R07
        (ce_i && ready_o && req_i && !we_i) |-> ##[1:20] rvalid_o)
        else $error("read never finished");
    // The strobe is one cycle, far above the short figure, but only
    // legal if the gate was already high before it fell
    a_write_strobe: assert property (@(posedge clk_i) disable iff (!rst_b_i)  // R14
        $fell(store_b_o) |-> gate_b_o && $past(gate_b_o))
        else $error("short strobe without gate high");
endmodule

/* tb/asrc_sram_model.sv */
// Behavioural byte-wide asynchronous static RAM, far side of the controller.
// Assumes the bench resolves the shared data lines from the host enable alone.
`timescale 1ns/10ps
module asrc_sram_model (
    input wire logic [asrc_pkg::ADDR_W-1:0] word_select_lines_i,
    input wire logic select_low_active_i,
    input wire logic select_high_active_i,
    input wire logic gate_b_i,
    input wire logic store_b_i,
    input wire logic [asrc_pkg::DATA_W-1:0] bidir_data_lines_i,
    output logic [asrc_pkg::DATA_W-1:0] bidir_data_lines_o,
    output logic bidir_data_lines_oe_o
);
    import asrc_pkg::*;
    // ------------------------------------------------------------
    // Storage and select
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem [0:8191];
    logic sel; // Combined select
    logic drive; // Read drive wanted
    assign sel = !select_low_active_i && select_high_active_i;
    assign drive = sel && !gate_b_i && store_b_i;
    initial begin
        bidir_data_lines_o = 8'h00;
        bidir_data_lines_oe_o = 1'b0;
    end
    // Level store: the strobe overlap with select writes
    always @(sel, store_b_i, word_select_lines_i, bidir_data_lines_i) begin
        if (sel && !store_b_i) begin
            mem[word_select_lines_i] = bidir_data_lines_i;
        end
    end
    // Off in 1 ns, on after 4 ns, so two parts never fight
    always @(drive) begin
        bidir_data_lines_oe_o <= #(drive ? 4 : 1) drive;
    end
    // Old byte held 4 ns, then junk until the access time
    always @(drive, word_select_lines_i) begin
        bidir_data_lines_o <= #4 ~bidir_data_lines_o;
        if (drive) begin
            bidir_data_lines_o <= #35 mem[word_select_lines_i];
        end
    end
endmodule

/* tb/testbench.sv */
// Self-checking bench: controller, behavioural RAM, reference array.
// Assumes one 10 MHz clock; inputs move 1 ns after each rising edge.
`timescale 1ns/10ps
module testbench;
    import asrc_pkg::*;
    logic clk_i, rst_b_i, ce_i, req_i, we_i, ready_o, rvalid_o;
    logic [ADDR_W-1:0] addr_i, wsl, ra;
    logic [DATA_W-1:0] wdata_i, rdata_o, h_do, m_do, bus;
    logic sla, sha, gate_b, store_b, h_oe, m_oe;
    logic [31:0] seed = 32'hc5391348;
    logic [DATA_W-1:0] ref_mem [int]; // Reference contents
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // Host drive wins; else whatever the RAM shows
    assign bus = h_oe ? h_do : m_do;
    asrc_ctrl i_asrc_ctrl (.clk_i, .rst_b_i, .ce_i, .req_i, .we_i, .addr_i, .wdata_i,
        .ready_o, .rdata_o, .rvalid_o, .word_select_lines_o(wsl),
        .select_low_active_o(sla), .select_high_active_o(sha), .gate_b_o(gate_b),
        .store_b_o(store_b), .bidir_data_lines_o(h_do), .bidir_data_lines_oe_o(h_oe),
        .bidir_data_lines_i(bus));
    asrc_sram_model i_asrc_sram_model (.word_select_lines_i(wsl),
        .select_low_active_i(sla), .select_high_active_i(sha), .gate_b_i(gate_b),
        .store_b_i(store_b), .bidir_data_lines_i(bus), .bidir_data_lines_o(m_do),
        .bidir_data_lines_oe_o(m_oe));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask
    task automatic final_report();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // One request; clock enable dithers while it runs
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        ce_i = 1'b1;
        req_i = 1'b1;
        we_i = w;
        addr_i = a;
        wdata_i = d;
        @(posedge clk_i);
        #1;
        req_i = 1'b0;
        n = 0;
        while ((w ? ready_o : rvalid_o) !== 1'b1 && n < 60) begin
            ce_i = (rnd() % 4) != 0;
            @(posedge clk_i);
            #1;
            n++;
        end
        if (w) begin
            ref_mem[a] = d;
        end else begin
            check(n < 60 && rdata_o === ref_mem[a], "read byte");
        end
        while (ready_o !== 1'b1 && n < 60) begin
            ce_i = 1'b1;
            @(posedge clk_i);
            #1;
            n++;
        end
        check(ready_o === 1'b1, "ready back");
    endtask
    // Pin watch mid-cycle, plus the hang limit
    always @(negedge clk_i) begin
        cycles++;
        if (h_oe && m_oe) check(1'b0, "bus fight");
        if (!store_b && !gate_b) check(1'b0, "strobe with gate low");
        if (cycles == 20000) begin
            check(1'b0, "timeout");
            final_report();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_b_i = 1'b0;
        ce_i = 1'b1;
        req_i = 1'b0;
        we_i = 1'b0;
        addr_i = '0;
        wdata_i = '0;
        repeat (5) @(posedge clk_i);
        #1;
        check(sla === 1'b1 && sha === 1'b0 && !h_oe && store_b && gate_b, "reset");
        rst_b_i = 1'b1;
        xfer(1'b1, 13'h0000, 8'h5a);
        xfer(1'b1, 13'h1fff, 8'ha5);
        xfer(1'b1, 13'h1fff, 8'h3c);
        xfer(1'b0, 13'h0000, 8'h00);
        xfer(1'b0, 13'h1fff, 8'h00);
        // Random mix, biased to a few words so reads hit
        for (int i = 0; i < 300; i++) begin
            ra = (rnd() % 2) ? ADDR_W'(rnd()) : ADDR_W'(rnd() % 8);
            if (ref_mem.exists(ra) && (rnd() % 2)) xfer(1'b0, ra, 8'h00);
            else xfer(1'b1, ra, DATA_W'(rnd()));
        end
        final_report();
    end
endmodule
